/* dv/software_watchdog_timer_tb_top.sv */
// self-checking bench for the software watchdog timer
// assumes the design files and wdt_pkg are compiled first
`timescale 1ns/100ps
module software_watchdog_timer_tb_top;
  import wdt_pkg::*;
  // ****************************************************************
  // setup
  // ****************************************************************
  // short counter keeps each time-out to a few dozen cycles
  localparam int unsigned CW   = 3;
  localparam int unsigned TOUT = 1 << CW;
  logic i_clk_sys                    = 1'b0;
  logic i_sys_rst                    = 1'b1;
  logic i_wdt_rc_osc                 = 1'b0;
  logic i_watchdog_enable_fuse       = 1'b1;
  logic i_clear_watchdog_instruction = 1'b0;
  logic i_sleep                      = 1'b0;
  logic o_wdt_reset;
  logic o_wdt_wake;
  logic o_timeout_status;
  logic o_enabled;
  logic o_external_master_reset_pin_drive_low;
  int   miscompares = 0;
  int   cmp_count   = 0;
  int   rst_cnt     = 0;
  int   wake_cnt    = 0;
  int   pin_bad     = 0;
  int   cyc         = 0;
  software_watchdog_timer #(.CNT_WIDTH(CW)) software_watchdog_timer_i (
    .i_clk_sys                             (i_clk_sys),
    .i_sys_rst                             (i_sys_rst),
    .i_wdt_rc_osc                          (i_wdt_rc_osc),
    .i_watchdog_enable_fuse                (i_watchdog_enable_fuse),
    .i_clear_watchdog_instruction          (i_clear_watchdog_instruction),
    .i_sleep                               (i_sleep),
    .o_wdt_reset                           (o_wdt_reset),
    .o_wdt_wake                            (o_wdt_wake),
    .o_timeout_status                      (o_timeout_status),
    .o_enabled                             (o_enabled),
    .o_external_master_reset_pin_drive_low (o_external_master_reset_pin_drive_low)
  );
  always #4 i_clk_sys = ~i_clk_sys;
  // pulses counted on the falling edge, clear of the tasks' rising-edge writes
  always @(negedge i_clk_sys) begin
    cyc++;
    if (o_wdt_reset === 1'b1) rst_cnt++;
    if (o_wdt_wake === 1'b1) wake_cnt++;
    if (o_external_master_reset_pin_drive_low !== PIN_DRIVE_LOW_RST) pin_bad++;
    if (cyc > 5000) begin
      miscompares++;
      results();
    end
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic fuse);
    i_watchdog_enable_fuse <= fuse;
    i_sys_rst              <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // one rc tick: three cycles high, three low
  task automatic tick(input int n);
    repeat (n) begin
      i_wdt_rc_osc <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_wdt_rc_osc <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
  task automatic clear_pulse();
    i_clear_watchdog_instruction <= 1'b1;
    @(posedge i_clk_sys);
    i_clear_watchdog_instruction <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_fuse_off();
    do_reset(1'b0);
    @(negedge i_clk_sys);
    check("enabled_erased", o_enabled, FUSE_ERASED_VALUE);
    check("status_rst", o_timeout_status, STATUS_RESET_VALUE);
    check("reset_rst", o_wdt_reset, 1'b0);
    check("wake_rst", o_wdt_wake, 1'b0);
    repeat (8) @(posedge i_clk_sys);
    check("enabled_off", o_enabled, 1'b0);
    rst_cnt = 0;
    tick(2 * TOUT);
    check("no_reset_off", rst_cnt, 0);
  endtask
  task automatic t_timeout();
    do_reset(1'b1);
    repeat (8) @(posedge i_clk_sys);
    check("enabled_on", o_enabled, 1'b1);
    // fuse pin moves after the load; the enable must not follow it
    i_watchdog_enable_fuse <= 1'b0;
    rst_cnt = 0;
    tick(TOUT - 1);
    check("reset_early", rst_cnt, 0);
    tick(1);
    check("reset_once", rst_cnt, 1);
    tick(TOUT);
    check("reset_wrap", rst_cnt, 2);
    check("enabled_static", o_enabled, 1'b1);
  endtask
  task automatic t_clear();
    rst_cnt = 0;
    tick(TOUT - 2);
    clear_pulse();
    tick(TOUT - 1);
    check("reset_after_clr", rst_cnt, 0);
    tick(1);
    check("reset_clr_to", rst_cnt, 1);
    check("no_wake_awake", wake_cnt, 0);
  endtask
  task automatic t_sleep();
    i_sleep  <= 1'b1;
    rst_cnt  = 0;
    wake_cnt = 0;
    tick(TOUT);
    check("wake_once", wake_cnt, 1);
    check("no_reset_slp", rst_cnt, 0);
    check("status_wake", o_timeout_status, 1'b0);
    check("enabled_wake", o_enabled, 1'b1);
    i_sleep <= 1'b0;
    tick(TOUT - 1);
    check("count_restart", rst_cnt, 0);
    clear_pulse();
    check("status_clr", o_timeout_status, 1'b1);
  endtask
  // ****************************************************************
  // sequence and verdict
  // ****************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    t_fuse_off();
    t_timeout();
    t_clear();
    t_sleep();
    check("pin_never_low", pin_bad, 0);
    results();
  end
endmodule

/* rtl/software_watchdog_timer.sv */
// software watchdog timer: free counter on rc oscillator ticks, reset or wake on overflow
// assumes the rc oscillator and the fuse arrive as pins; sleep and clear from cpu logic
`timescale 1ns/100ps
// Notes on behaviour
// - The counter advances on ticks of a dedicated rc oscillator, not on the processor clock; here the ticks are sampled on i_clk_sys and stop with it.
// - Only the non-volatile enable fuse decides whether the watchdog runs.
// - A fuse value of one makes the counter active and zero keeps it inactive.
// - An erased fuse reads as one so the watchdog is enabled by default.
// - While enabled the counter increments until it overflows, which is a time-out.
// - A time-out outside sleep forces a full device reset.
// - A time-out during sleep wakes the device instead of resetting it.
// - A wake by time-out clears the time-out status bit to zero.
// - The watchdog reset is internal and never pulls the external master reset pin low.
// - A wake by time-out leaves the rest of the state unchanged.
module software_watchdog_timer #(
  parameter int unsigned CNT_WIDTH = wdt_pkg::CNT_WIDTH_DEFAULT
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // pins
  input  wire logic i_wdt_rc_osc,
  input  wire logic i_watchdog_enable_fuse,
  // cpu side
  input  wire logic i_clear_watchdog_instruction,
  input  wire logic i_sleep,
  // outputs
  output logic      o_wdt_reset,
  output logic      o_wdt_wake,
  output logic      o_timeout_status,
  output logic      o_enabled,
  output logic      o_external_master_reset_pin_drive_low
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [CNT_WIDTH-1:0] cnt;
    logic [1:0]           boot;
    logic                 loaded;
    logic                 en;
    logic                 rst_pulse;
    logic                 wake_pulse;
    logic                 status;
    logic                 pin_low;
  } wdt_state_t;

  wdt_state_t s_q;
  wdt_state_t s_d;

  logic rc_tick;
  logic fuse_level;
  logic overflow;

  localparam logic [CNT_WIDTH-1:0] CNT_MAX  = '1;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = '0;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE  = CNT_WIDTH'(1);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // one clock only: a dead system clock also stops the count here
  wdt_sync_edge u_rc_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_wdt_rc_osc),
    .o_level   (),
    .o_rise    (rc_tick)
  );

  wdt_sync_edge u_fuse_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_watchdog_enable_fuse),
    .o_level   (fuse_level),
    .o_rise    ()
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  assign overflow = s_q.en & rc_tick & ~i_clear_watchdog_instruction & (s_q.cnt == CNT_MAX);

  always_comb begin
    s_d            = s_q;
    s_d.rst_pulse  = 1'b0;
    s_d.wake_pulse = 1'b0;
    s_d.pin_low    = PIN_DRIVE_LOW_RST;
    // fuse sampled once after the synchroniser settles; no run-time path
    if (!s_q.loaded) begin
      if (s_q.boot == BOOT_CYCLES) begin
        s_d.loaded = 1'b1;
        s_d.en     = fuse_level;
      end else begin
        s_d.boot = s_q.boot + 2'h1;
      end
    end
    if (!s_q.en) begin
      s_d.cnt = CNT_ZERO;
    end else if (i_clear_watchdog_instruction) begin
      s_d.cnt = CNT_ZERO;
    end else if (rc_tick) begin
      s_d.cnt = s_q.cnt + CNT_ONE;
    end
    if (i_clear_watchdog_instruction) begin
      s_d.status = 1'b1;
    end
    // a clear in the same cycle masks the overflow, so the clear wins and no wake occurs
    if (overflow) begin
      if (i_sleep) begin
        s_d.wake_pulse = 1'b1;
        s_d.status     = 1'b0;
      end else begin
        s_d.rst_pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_q         <= '0;
      s_q.boot    <= BOOT_RESET;
      s_q.en      <= FUSE_ERASED_VALUE;
      s_q.status  <= STATUS_RESET_VALUE;
      s_q.pin_low <= PIN_DRIVE_LOW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_wdt_reset                           = s_q.rst_pulse;
  assign o_wdt_wake                            = s_q.wake_pulse;
  assign o_timeout_status                      = s_q.status;
  assign o_enabled                             = s_q.en;
  assign o_external_master_reset_pin_drive_low = s_q.pin_low;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_disabled_idle;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      !s_q.en |=> (s_q.cnt == CNT_ZERO) && !o_wdt_reset && !o_wdt_wake;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled watchdog moved");

  property p_enable_static;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.loaded |=> s_q.loaded && $stable(s_q.en);
  endproperty
  a_enable_static: assert property (p_enable_static) else $error("enable changed at run time");

  property p_erased_default;
    @(posedge i_clk_sys)
      i_sys_rst |=> s_q.en == FUSE_ERASED_VALUE;
  endproperty
  a_erased_default: assert property (p_erased_default) else $error("enable not one after reset");

  property p_count_up;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.en && rc_tick && !i_clear_watchdog_instruction && s_q.cnt != CNT_MAX
      |=> s_q.cnt == $past(s_q.cnt) + CNT_ONE;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step on tick");

  property p_awake_reset;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      overflow && !i_sleep |=> o_wdt_reset && !o_wdt_wake ##1 !o_wdt_reset;
  endproperty
  a_awake_reset: assert property (p_awake_reset) else $error("no single reset pulse");

  property p_sleep_wake;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      overflow && i_sleep |=> o_wdt_wake && !o_wdt_reset && !o_timeout_status;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep time-out did not wake");

  property p_clear_restarts;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      i_clear_watchdog_instruction |=> s_q.cnt == CNT_ZERO && o_timeout_status;
  endproperty
  a_clear_restarts: assert property (p_clear_restarts) else $error("clear did not restart");

  property p_pin_untouched;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_wdt_reset |-> !o_external_master_reset_pin_drive_low;
  endproperty
  a_pin_untouched: assert property (p_pin_untouched) else $error("reset pin pulled low");

  property p_wake_keeps_state;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_wdt_wake |-> s_q.en && s_q.cnt == CNT_ZERO && $stable(s_q.en);
  endproperty
  a_wake_keeps_state: assert property (p_wake_keeps_state) else $error("wake disturbed state");

endmodule

/* rtl/wdt_sync_edge.sv */
// two-flop synchroniser with a rising-edge pulse on the synchronised level
// assumes i_async is asynchronous to i_clk_sys
`timescale 1ns/100ps
module wdt_sync_edge (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // raw input
  input  wire logic i_async,
  // synchronised outputs
  output logic      o_level,
  output logic      o_rise
);
  import wdt_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = i_async;
    // first stage only feeds the second
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.rise = s_q.sync & ~s_q.prev;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.sync;
  assign o_rise  = s_q.rise;

endmodule

/* shared/wdt_pkg.sv */
// shared constants of the software watchdog timer
// assumes one system clock domain; the rc oscillator arrives as a pin level
package wdt_pkg;

  // ****************************************************************
  // counter shape
  // ****************************************************************
  localparam int unsigned CNT_WIDTH_DEFAULT = 16;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic FUSE_ERASED_VALUE  = 1'b1;
  localparam logic STATUS_RESET_VALUE = 1'b1;
  localparam logic PIN_DRIVE_LOW_RST  = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SYNC_STAGES   = 2;
  // cycles after reset release before the fuse level is trusted
  localparam logic [1:0] BOOT_CYCLES    = 2'h3;
  localparam logic [1:0] BOOT_RESET     = 2'h0;

endpackage
